/* File: design/mrl_consts.svh */
// timing constants for the main relay control block
`ifndef MRL_CONSTS_SVH
`define MRL_CONSTS_SVH
// clock period in ns (40 MHz)
`define MRL_CLK_PERIOD_NS 25
// shortest overcurrent filter time in ns
`define MRL_OVC_FILTER_NS 5250
// filter time in clock cycles, least time rounded up
`define MRL_OVC_FILTER_CYC \
  ((`MRL_OVC_FILTER_NS + `MRL_CLK_PERIOD_NS - 1) / `MRL_CLK_PERIOD_NS)
// width of the overcurrent filter counter
`define MRL_OVC_CNT_W 8
`endif

/* File: design/mrl_pkg.sv */
// types shared by the main relay control block
package mrl_pkg;
  // pin-level indications from the analogue front end
  typedef struct packed {
    logic key_on;
    logic battery_present_level;
    logic battery_low_threshold;
    logic overtemp;
    logic overcurrent_threshold;
  } mrl_pins_s;

  // relay control states
  typedef enum logic [1:0] {
    MRL_RUN,
    MRL_WAIT_REACT,
    MRL_RETRY,
    MRL_WAIT_KEY
  } mrl_state_e;
endpackage : mrl_pkg

/* File: design/mrl_ctrl.sv */
// main relay output control with overtemperature and overcurrent handling
// Notes on behaviour
// R1: relay follows key or power latch, unless host requests off
// R2: overtemperature with battery present forces relay off
// R3: overtemperature release resumes relay without host action
// R4: filtered overcurrent without battery switches relay off
// R5: then stay off until key falls
// R6: with battery, host reactivation retries after overcurrent
// R7: battery low: retry once, then await key fall
// R8: flag shows relay off from earlier overcurrent
// R9: host tests short to ground by switching off
// R10: filter restarts whenever overcurrent indication drops
`include "mrl_consts.svh"
module mrl_ctrl
  import mrl_pkg::*;
#(
  parameter int FILT_CYC = `MRL_OVC_FILTER_CYC,
  parameter int CNT_W = `MRL_OVC_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous pin indications
  input wire mrl_pins_s pins,
  // host controls on this clock
  input wire logic power_latch,
  input wire logic relay_off_req,
  input wire logic relay_reactivate_cmd,
  // relay output and status
  output logic main_relay_output,
  output logic relay_overcurrent_flag
);

  localparam logic [CNT_W-1:0] TRIP_AT = CNT_W'(FILT_CYC - 1);

  mrl_pins_s sync1_r;
  mrl_pins_s sync2_r;
  logic key_prev_r;
  logic [CNT_W-1:0] ovc_cnt_r;
  mrl_state_e state_r;
  mrl_state_e state_nxt;
  logic want_on;
  logic ot_block;
  logic key_fall;
  logic ovc_trip;
  logic drive_nxt;

  // states in which the relay is held off by an overcurrent
  function automatic logic ovc_off(input mrl_state_e s);
    return (s == MRL_WAIT_REACT) || (s == MRL_WAIT_KEY);
  endfunction : ovc_off

  // two-flop synchroniser for every pin indication
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // previous key level for edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      key_prev_r <= 1'b0;
    end else begin
      key_prev_r <= sync2_r.key_on;
    end
  end

  // demand, thermal block and key edge
  assign want_on = (sync2_r.key_on | power_latch) & ~relay_off_req; // [R1]
  assign ot_block = sync2_r.battery_present_level & sync2_r.overtemp; // [R2]
  assign key_fall = key_prev_r & ~sync2_r.key_on; // [R5]

  // overcurrent filter, counts only a continuous overcurrent
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovc_cnt_r <= '0;
    end else if (!sync2_r.overcurrent_threshold || !main_relay_output) begin
      ovc_cnt_r <= '0; // [R10]
    end else if (ovc_cnt_r != TRIP_AT) begin
      ovc_cnt_r <= ovc_cnt_r + CNT_W'(1);
    end
  end

  assign ovc_trip = main_relay_output & sync2_r.overcurrent_threshold
                    & (ovc_cnt_r == TRIP_AT); // [R4]

  // next relay control state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MRL_RUN: begin
        if (ovc_trip && sync2_r.battery_present_level) begin
          state_nxt = MRL_WAIT_REACT; // [R6]
        end else if (ovc_trip) begin
          state_nxt = MRL_WAIT_KEY; // [R4]
        end
      end
      MRL_WAIT_REACT: begin
        if (!sync2_r.battery_low_threshold) begin
          state_nxt = MRL_RETRY; // [R7]
        end else if (relay_reactivate_cmd) begin
          state_nxt = MRL_RUN; // [R6]
        end
      end
      MRL_RETRY: begin
        if (ovc_trip) begin
          state_nxt = MRL_WAIT_KEY; // [R7]
        end else if (sync2_r.battery_low_threshold) begin
          state_nxt = MRL_RUN;
        end
      end
      MRL_WAIT_KEY: begin
        if (key_fall) begin
          state_nxt = MRL_RUN; // [R5]
        end
      end
      default: state_nxt = MRL_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= MRL_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // relay drive: only in run or retry, with demand and no thermal block
  assign drive_nxt = ((state_r == MRL_RUN) || (state_r == MRL_RETRY))
                     & want_on & ~ot_block & ~ovc_trip; // [R1] [R2] [R3]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      main_relay_output <= 1'b0;
    end else begin
      main_relay_output <= drive_nxt;
    end
  end

  // overcurrent status follows the latched-off states
  always_ff @(posedge clk) begin
    if (!nrst) begin
      relay_overcurrent_flag <= 1'b0;
    end else begin
      relay_overcurrent_flag <= ovc_off(state_nxt); // [R8]
    end
  end

  // thermal cut-off with battery present
  a_ot_cutoff: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    ot_block |-> ##1 !main_relay_output)
    else $error("relay on during overtemperature");

  // thermal recovery without host action
  a_ot_recover: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    (state_r == MRL_RUN) && want_on && $fell(ot_block)
      && !ovc_trip |-> ##1 main_relay_output)
    else $error("relay not resumed after overtemperature");

  // no demand means relay off
  a_demand_off: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    !want_on |-> ##1 !main_relay_output)
    else $error("relay on without demand");

  // filtered overcurrent without battery latches off
  a_filter_trip: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    (state_r == MRL_RUN) && main_relay_output
      && sync2_r.overcurrent_threshold && !sync2_r.battery_present_level
      && (ovc_cnt_r == TRIP_AT)
      |-> ##1 (state_r == MRL_WAIT_KEY) && !main_relay_output)
    else $error("overcurrent trip without battery missed");

  // key-fall wait holds the relay off
  a_key_hold: assert property (@(posedge clk) disable iff (!nrst) // [R5]
    (state_r == MRL_WAIT_KEY) && !key_fall
      |-> ##1 (state_r == MRL_WAIT_KEY) && !main_relay_output)
    else $error("relay left key wait without key fall");

  // host reactivation with battery above low threshold
  a_react_retry: assert property (@(posedge clk) disable iff (!nrst) // [R6]
    (state_r == MRL_WAIT_REACT) && relay_reactivate_cmd
      && sync2_r.battery_low_threshold |-> ##1 (state_r == MRL_RUN))
    else $error("reactivation command ignored");

  // low battery triggers a single retry
  a_low_retry: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    (state_r == MRL_WAIT_REACT) && !sync2_r.battery_low_threshold
      |-> ##1 (state_r == MRL_RETRY))
    else $error("no retry at low battery");

  // status flag tracks overcurrent off states
  a_flag_match: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    ##1 relay_overcurrent_flag == ovc_off(state_r))
    else $error("overcurrent flag mismatch");

  // filter restart on inactive indication
  a_filter_restart: assert property (@(posedge clk) // [R10]
    disable iff (!nrst)
    !sync2_r.overcurrent_threshold |-> ##1 (ovc_cnt_r == '0))
    else $error("filter not restarted");

  // an overcurrent trip always raises the status flag
  a_trip_flag: assert property (@(posedge clk) disable iff (!nrst) // [R8]
    ovc_trip |-> ##1 relay_overcurrent_flag && !main_relay_output)
    else $error("overcurrent trip without status flag");

  // second trip during the low-battery retry waits for the key
  a_retry_trip: assert property (@(posedge clk) disable iff (!nrst) // [R7]
    (state_r == MRL_RETRY) && ovc_trip
      |-> ##1 (state_r == MRL_WAIT_KEY) && !main_relay_output)
    else $error("retry trip did not latch off");

  // with battery above low threshold, reactivation wait holds the relay off until commanded
  a_react_wait: assert property (@(posedge clk) disable iff (!nrst) // [R6]
    (state_r == MRL_WAIT_REACT) && !relay_reactivate_cmd
      && sync2_r.battery_low_threshold
      |-> ##1 (state_r == MRL_WAIT_REACT) && !main_relay_output)
    else $error("relay left reactivation wait uncommanded");

  // no shutdown before the filter time has run out
  a_filter_early: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    (state_r == MRL_RUN) && (ovc_cnt_r != TRIP_AT)
      |-> ##1 (state_r == MRL_RUN))
    else $error("overcurrent shutdown before filter time");

endmodule : mrl_ctrl

/* File: dv/mrl_load.sv */
// relay coil load model with a short-to-battery fault switch
module mrl_load (
  // relay drive from the block
  input wire logic main_relay_output,
  // fault switch from the bench
  input wire logic short_bat,
  // current indication back to the block
  output logic overcurrent_threshold
);
  timeunit 1ns;
  timeprecision 1ps;
  // over threshold only while driven into the short
  assign overcurrent_threshold = main_relay_output & short_bat;
endmodule : mrl_load

/* File: dv/testbench.sv */
// self-checking bench for the main relay control block
module testbench import mrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, latch, off_req, react, key, bp, bl, ot, short_bat;
  logic oc, out, flag;
  mrl_pins_s pins;
  int n_mismatch = 0;
  int checks_done = 0;
  // pin bundle, fault current from the load model
  assign pins = {key, bp, bl, ot, oc};
  mrl_ctrl #(.FILT_CYC(4), .CNT_W(8)) i_dut (.clk(clk), .nrst(nrst),
    .pins(pins), .power_latch(latch), .relay_off_req(off_req),
    .relay_reactivate_cmd(react), .main_relay_output(out),
    .relay_overcurrent_flag(flag));
  mrl_load i_load (.main_relay_output(out), .short_bat(short_bat),
    .overcurrent_threshold(oc));
  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task print_verdict;
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // wait a bounded time for {out, flag} to reach exp
  task settle(input logic [1:0] exp);
    for (int i = 0; i < 16 && {out, flag} !== exp; i++) step(1);
    checks_done++;
    if ({out, flag} !== exp) begin
      n_mismatch++;
      $display("BAD %0t exp %h got %h", $time, exp, {out, flag});
      print_verdict();
    end
  endtask : settle
  // outputs must stay at exp for n cycles
  task hold(input logic [1:0] exp, input int n);
    repeat (n) begin
      step(1);
      checks_done++;
      if ({out, flag} !== exp) begin
        n_mismatch++;
        $display("BAD %0t exp %h got %h", $time, exp, {out, flag});
      end
    end
  endtask : hold
  task sc_demand;
    key = 1'b1;
    bp = 1'b1;
    bl = 1'b1;
    settle(2'h2);
    key = 1'b0;
    settle(2'h0);
    latch = 1'b1;
    settle(2'h2);
    off_req = 1'b1;
    settle(2'h0);
    off_req = 1'b0;
    settle(2'h2);
  endtask : sc_demand
  task sc_overtemp;
    ot = 1'b1;
    settle(2'h0);
    ot = 1'b0;
    settle(2'h2);
  endtask : sc_overtemp
  // short bursts, each below the filter time
  task sc_filter;
    repeat (6) begin
      short_bat = 1'b1;
      step(2);
      short_bat = 1'b0;
      step(2);
    end
    hold(2'h2, 8);
  endtask : sc_filter
  task sc_nobat;
    key = 1'b1;
    bp = 1'b0;
    short_bat = 1'b1;
    hold(2'h2, 5);
    settle(2'h1);
    short_bat = 1'b0;
    hold(2'h1, 8);
    key = 1'b0;
    settle(2'h2);
  endtask : sc_nobat
  task sc_react;
    bp = 1'b1;
    short_bat = 1'b1;
    settle(2'h1);
    short_bat = 1'b0;
    hold(2'h1, 6);
    react = 1'b1;
    step(1);
    react = 1'b0;
    settle(2'h2);
  endtask : sc_react
  task sc_lowbat;
    key = 1'b1;
    short_bat = 1'b1;
    settle(2'h1);
    bl = 1'b0;
    settle(2'h2);
    settle(2'h1);
    bl = 1'b1;
    short_bat = 1'b0;
    hold(2'h1, 6);
    key = 1'b0;
    settle(2'h2);
  endtask : sc_lowbat
  // reset, then the scenarios in turn
  initial begin
    {nrst, latch, off_req, react, key, bp, bl, ot, short_bat} = 9'h000;
    step(2);
    nrst = 1'b1;
    settle(2'h0);
    sc_demand();
    sc_overtemp();
    sc_filter();
    sc_nobat();
    sc_react();
    sc_lowbat();
    print_verdict();
  end
endmodule : testbench
